// file: eim_pkg.sv
// constants shared by the ecc interrupt mask and error location block
package eim_pkg;
	// ========================================================
	// structure
	localparam int unsigned NSLICE = 4;  // 64-bit slices in the data word
	localparam int unsigned NEVT   = 5;  // interrupt event sources
	localparam int unsigned CTRL_W = 12; // implemented control word bits

	// ========================================================
	// register word indices, byte address is index times four
	localparam logic [3:0] IDX_CTRL  = 4'h0;
	localparam logic [3:0] IDX_ISTAT = 4'hA;
	localparam logic [3:0] IDX_IMASK = 4'hB;
	localparam logic [3:0] IDX_SLOC  = 4'hC;
	localparam logic [3:0] IDX_DLOC  = 4'hD;

	// ========================================================
	// event bit positions in status and mask
	localparam int unsigned EV_SBE     = 0;
	localparam int unsigned EV_DBE     = 1;
	localparam int unsigned EV_SBE_MAX = 2;
	localparam int unsigned EV_DBE_MAX = 3;
	localparam int unsigned EV_RMW_DBE = 4;

	// ========================================================
	// control word action bits
	localparam int unsigned CTRL_CLR_ALL = 4;
	localparam int unsigned CTRL_CLR_IRQ = 11;

	// ========================================================
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST  = 12'h00F;
	localparam logic [NEVT-1:0]   MASK_RST  = 5'h01;
	localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;
endpackage : eim_pkg

// file: eim_sticky.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module eim_sticky #(
	parameter int unsigned W = 4
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output var  logic [W-1:0] flag_o
);
	// ========================================================
	// one flop per flag
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_flag
			// an event in the clearing cycle is kept
			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) begin
					flag_o[i] <= 1'b0;
				end else begin
					flag_o[i] <= set_i[i] | (flag_o[i] & ~clr_i[i]);
				end
			end
		end
	endgenerate
endmodule : eim_sticky
`default_nettype wire

// file: eim_tb.sv
// self-checking bench for the ecc interrupt mask and location block
`timescale 1ns/100ps
`default_nettype none
module eim_tb;
	import eim_pkg::*;
	// ==========================================================
	// clock, reset and design ports
	logic              clk_sys_i   = 1'b0;
	logic              rst_i       = 1'b1;
	logic              wb_cyc_i    = 1'b0;
	logic              wb_stb_i    = 1'b0;
	logic              wb_we_i     = 1'b0;
	logic [5:0]        wb_adr_i    = 6'h00;
	logic [3:0]        wb_sel_i    = 4'hF;
	logic [31:0]       wb_dat_i    = 32'h0000_0000;
	logic [31:0]       wb_dat_o;
	logic              wb_ack_o;
	logic              sbe_event_i = 1'b0;
	logic              dbe_event_i = 1'b0;
	logic [NSLICE-1:0] sbe_slice_i = 4'h0;
	logic [NSLICE-1:0] dbe_slice_i = 4'h0;
	logic              sbe_over_i  = 1'b0;
	logic              dbe_over_i  = 1'b0;
	logic              rmw_dbe_i   = 1'b0;
	logic [CTRL_W-1:0] ctrl_o;
	logic              irq_o;
	int                bad_count   = 0;
	int                check_count = 0;
	int                i;

	// free running 125 MHz clock
	always #4 clk_sys_i = ~clk_sys_i;

	eim_top u_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sbe_event_i(sbe_event_i), .dbe_event_i(dbe_event_i),
		.sbe_slice_i(sbe_slice_i), .dbe_slice_i(dbe_slice_i),
		.sbe_over_i(sbe_over_i), .dbe_over_i(dbe_over_i),
		.rmw_dbe_i(rmw_dbe_i), .ctrl_o(ctrl_o), .irq_o(irq_o)
	);

	// ==========================================================
	// verdict and comparison
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask : chk

	// ==========================================================
	// wishbone classic single access, waits for ack with a bound
	task wb(input logic we, input logic [3:0] idx, input logic [31:0] wd,
		output logic [31:0] rdat);
		int n;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= wd;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys_i);
			if (wb_ack_o === 1'b1) break;
		end
		if (n == 20) begin
			bad_count++;
			end_sim();
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb

	task wr(input logic [3:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		wb(1'b1, idx, wd, d);
	endtask : wr

	task rdc(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		wb(1'b0, idx, 32'h0000_0000, d);
		chk(d, exp);
	endtask : rdc

	// one-cycle event pulses with their slice vectors
	task ev(input logic [4:0] e, input logic [3:0] ss, input logic [3:0] ds);
		@(posedge clk_sys_i);
		sbe_event_i <= e[0];
		dbe_event_i <= e[1];
		sbe_over_i  <= e[2];
		dbe_over_i  <= e[3];
		rmw_dbe_i   <= e[4];
		sbe_slice_i <= ss;
		dbe_slice_i <= ds;
		@(posedge clk_sys_i);
		{sbe_event_i, dbe_event_i, sbe_over_i, dbe_over_i} <= 4'h0;
		rmw_dbe_i   <= 1'b0;
		sbe_slice_i <= 4'h0;
		dbe_slice_i <= 4'h0;
	endtask : ev

	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick

	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(IDX_CTRL, 32'h0000_000F);
		rdc(IDX_ISTAT, 32'h0000_0000);
		rdc(IDX_SLOC, 32'h0000_0000);
		rdc(IDX_DLOC, 32'h0000_0000);
		// mask after reset holds single-bit errors off the interrupt
		ev(5'h01, 4'h1, 4'h0);
		tick(3);
		chk({31'h0, irq_o}, 32'h0000_0000);
		// each source: recorded while masked, raises irq once unmasked
		for (i = 0; i < NEVT; i++) begin
			wr(IDX_IMASK, 32'h0000_001F);
			ev(5'h01 << i, 4'h0, 4'h0);
			tick(3);
			chk({31'h0, irq_o}, 32'h0000_0000);
			rdc(IDX_ISTAT, 32'h0000_0001 << i);
			wr(IDX_IMASK, ~(32'h0000_0001 << i) & 32'h0000_001F);
			tick(2);
			chk({31'h0, irq_o}, 32'h0000_0001);
			wr(IDX_ISTAT, 32'h0000_0001 << i);
			tick(3);
			chk({31'h0, irq_o}, 32'h0000_0000);
		end
		// slice locations, write-one-clear and clear through control
		ev(5'h03, 4'h5, 4'hA);
		tick(1);
		rdc(IDX_SLOC, 32'h0000_0005);
		rdc(IDX_DLOC, 32'h0000_000A);
		wr(IDX_SLOC, 32'h0000_0001);
		wr(IDX_DLOC, 32'h0000_0000);
		rdc(IDX_SLOC, 32'h0000_0004);
		rdc(IDX_DLOC, 32'h0000_000A);
		wr(IDX_DLOC, 32'h0000_0008);
		rdc(IDX_DLOC, 32'h0000_0002);
		wr(IDX_CTRL, 32'h0000_001F);
		rdc(IDX_SLOC, 32'h0000_0000);
		rdc(IDX_DLOC, 32'h0000_0000);
		// pending interrupt cleared by control bit 11
		wr(IDX_IMASK, 32'h0000_0000);
		ev(5'h1F, 4'hF, 4'hF);
		tick(3);
		chk({31'h0, irq_o}, 32'h0000_0001);
		wr(IDX_CTRL, 32'h0000_080F);
		tick(3);
		chk({31'h0, irq_o}, 32'h0000_0000);
		rdc(IDX_ISTAT, 32'h0000_0000);
		rdc(IDX_CTRL, 32'h0000_000F);
		// control bits reach the output, bit 11 never sticks
		wr(IDX_CTRL, 32'h0000_0F03);
		tick(1);
		chk({20'h0_0000, ctrl_o}, 32'h0000_0703);
		rdc(IDX_CTRL, 32'h0000_0703);
		end_sim();
	end
endmodule : eim_tb
`default_nettype wire

// file: eim_top.sv
// ecc interrupt mask, interrupt status and error slice location registers
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// R1: mask bit 0 blocks single-bit error interrupt; clear lets it through.
// R2: mask bit 1 blocks double-bit error interrupt; clear lets it through.
// R3: mask bit 2 blocks single-bit threshold overrun interrupt.
// R4: mask bit 3 blocks double-bit threshold overrun interrupt.
// R5: mask bit 4 blocks read-modify-write double-bit error interrupt.
// R6: single-bit location holds one sticky bit per 64-bit slice.
// R7: double-bit location holds one sticky bit per 64-bit slice.
// R8: status bits 0..4 record sbe, dbe, two overruns, rmw dbe.
// R9: writing one clears a location bit; zero leaves it.
// R10: counter crossing its maximum raises interrupt, subject to mask.
// R11: writing one to control bit 11 clears the pending interrupt.
// R12: interrupt is OR of unmasked status; masked events still recorded.
module eim_top (
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_i,
	// wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [5:0]                 wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	// error events from the codec and counters
	input  wire logic                       sbe_event_i,
	input  wire logic                       dbe_event_i,
	input  wire logic [eim_pkg::NSLICE-1:0] sbe_slice_i,
	input  wire logic [eim_pkg::NSLICE-1:0] dbe_slice_i,
	input  wire logic                       sbe_over_i,
	input  wire logic                       dbe_over_i,
	input  wire logic                       rmw_dbe_i,
	// control and interrupt
	output logic [eim_pkg::CTRL_W-1:0]      ctrl_o,
	output logic                            irq_o
);
	import eim_pkg::*;

	// ========================================================
	// state
	logic                 ack_r;
	logic [31:0]          dat_r;
	logic [CTRL_W-1:0]    ctrl_r;
	logic [CTRL_W-1:0]    ctrl_nxt;
	logic [NEVT-1:0]      mask_r;
	logic [NEVT-1:0]      mask_nxt;
	logic                 irq_r;
	logic [NEVT-1:0]      stat_r;
	logic [NSLICE-1:0]    sloc_r;
	logic [NSLICE-1:0]    dloc_r;

	// ========================================================
	// bus decode
	wire        req     = wb_cyc_i & wb_stb_i;
	wire [3:0]  idx     = wb_adr_i[5:2];
	wire        wr_fire = req & wb_we_i & ack_r; // write lands at the ack edge
	wire [31:0] lanes   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wdat    = wb_dat_i & lanes;
	wire        hit_ctl = (idx == IDX_CTRL);
	wire        hit_ist = (idx == IDX_ISTAT);
	wire        hit_msk = (idx == IDX_IMASK);
	wire        hit_slc = (idx == IDX_SLOC);
	wire        hit_dlc = (idx == IDX_DLOC);

	// ========================================================
	// control word: action bits act on write and read back zero
	wire clr_irq = wr_fire & hit_ctl & wdat[CTRL_CLR_IRQ];
	wire clr_all = wr_fire & hit_ctl & wdat[CTRL_CLR_ALL];
	wire [CTRL_W-1:0] act_bits = (12'h001 << CTRL_CLR_IRQ)
	                           | (12'h001 << CTRL_CLR_ALL);
	assign ctrl_nxt = (wr_fire & hit_ctl)
		? (((ctrl_r & ~lanes[CTRL_W-1:0]) | wdat[CTRL_W-1:0]) & ~act_bits)
		: ctrl_r;

	// mask register, byte lane 0 only
	assign mask_nxt = (wr_fire & hit_msk & wb_sel_i[0])
		? wb_dat_i[NEVT-1:0] : mask_r;

	// ========================================================
	// interrupt status sources
	// R8 status bit order
	// R10 threshold overruns
	wire [NEVT-1:0] evt = {rmw_dbe_i, dbe_over_i, sbe_over_i,
	                       dbe_event_i, sbe_event_i};
	// R11 clear all pending
	wire [NEVT-1:0] stat_clr = ((wr_fire & hit_ist) ? wdat[NEVT-1:0]
		: {NEVT{1'b0}}) | {NEVT{clr_irq}};

	eim_sticky #(.W(NEVT)) u_stat (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.set_i     (evt),
		.clr_i     (stat_clr),
		.flag_o    (stat_r)
	);

	// ========================================================
	// slice location flags
	// R6 single-bit slices
	// R7 double-bit slices
	wire [NSLICE-1:0] sloc_set = sbe_event_i ? sbe_slice_i : {NSLICE{1'b0}};
	wire [NSLICE-1:0] dloc_set = dbe_event_i ? dbe_slice_i : {NSLICE{1'b0}};
	// R9 write one clears
	wire [NSLICE-1:0] sloc_clr = ((wr_fire & hit_slc) ? wdat[NSLICE-1:0]
		: {NSLICE{1'b0}}) | {NSLICE{clr_all}};
	wire [NSLICE-1:0] dloc_clr = ((wr_fire & hit_dlc) ? wdat[NSLICE-1:0]
		: {NSLICE{1'b0}}) | {NSLICE{clr_all}};

	eim_sticky #(.W(NSLICE)) u_sloc (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.set_i     (sloc_set),
		.clr_i     (sloc_clr),
		.flag_o    (sloc_r)
	);

	eim_sticky #(.W(NSLICE)) u_dloc (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.set_i     (dloc_set),
		.clr_i     (dloc_clr),
		.flag_o    (dloc_r)
	);

	// ========================================================
	// interrupt: unmasked status only, masking never hides status
	// R1 sbe mask
	// R2 dbe mask
	// R3 sbe overrun mask
	// R4 dbe overrun mask
	// R5 rmw mask
	// R12 or of unmasked
	wire irq_nxt = |(stat_r & ~mask_r);

	// ========================================================
	// read mux, unmapped and write-only words read zero
	wire [31:0] rd_mux =
		hit_ctl ? {{(32-CTRL_W){1'b0}}, ctrl_r} :
		hit_ist ? {{(32-NEVT){1'b0}}, stat_r} :
		hit_slc ? {{(32-NSLICE){1'b0}}, sloc_r} :
		hit_dlc ? {{(32-NSLICE){1'b0}}, dloc_r} :
		WORD_ZERO;

	// bus answer one cycle after the request, dropped the next
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= WORD_ZERO;
		end else begin
			ack_r <= req & ~ack_r;
			dat_r <= (req & ~ack_r) ? rd_mux : dat_r;
		end
	end

	// software registers and interrupt flop
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RST;
			mask_r <= MASK_RST;
			irq_r  <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			irq_r  <= irq_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign ctrl_o   = ctrl_r;
	assign irq_o    = irq_r;

	// ========================================================
	// checks
	sequence s_only(int unsigned b);
		stat_r == (5'h01 << b);
	endsequence

	sequence s_ctl_clr;
		wr_fire && hit_ctl && wdat[CTRL_CLR_IRQ] && !(|evt);
	endsequence

	property p_sbe_masked;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_only(EV_SBE) and mask_r[EV_SBE] |=> !irq_o;
	endproperty
	a_sbe_masked: assert property (p_sbe_masked) // R1
		else $error("masked single-bit error raised interrupt");

	property p_dbe_masked;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_only(EV_DBE) and mask_r[EV_DBE] |=> !irq_o;
	endproperty
	a_dbe_masked: assert property (p_dbe_masked) // R2
		else $error("masked double-bit error raised interrupt");

	property p_smax_masked;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_only(EV_SBE_MAX) and mask_r[EV_SBE_MAX] |=> !irq_o;
	endproperty
	a_smax_masked: assert property (p_smax_masked) // R3
		else $error("masked single-bit overrun raised interrupt");

	property p_dmax_masked;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_only(EV_DBE_MAX) and mask_r[EV_DBE_MAX] |=> !irq_o;
	endproperty
	a_dmax_masked: assert property (p_dmax_masked) // R4
		else $error("masked double-bit overrun raised interrupt");

	property p_rmw_masked;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_only(EV_RMW_DBE) and mask_r[EV_RMW_DBE] |=> !irq_o;
	endproperty
	a_rmw_masked: assert property (p_rmw_masked) // R5
		else $error("masked rmw double-bit error raised interrupt");

	property p_sloc_set;
		@(posedge clk_sys_i) disable iff (rst_i)
		sbe_event_i |=> ((sloc_r & $past(sbe_slice_i)) == $past(sbe_slice_i));
	endproperty
	a_sloc_set: assert property (p_sloc_set) // R6
		else $error("single-bit slice flag not set");

	property p_dloc_set;
		@(posedge clk_sys_i) disable iff (rst_i)
		dbe_event_i |=> ((dloc_r & $past(dbe_slice_i)) == $past(dbe_slice_i));
	endproperty
	a_dloc_set: assert property (p_dloc_set) // R7
		else $error("double-bit slice flag not set");

	property p_evt_status;
		@(posedge clk_sys_i) disable iff (rst_i)
		sbe_event_i && dbe_event_i |=> stat_r[EV_SBE] && stat_r[EV_DBE];
	endproperty
	a_evt_status: assert property (p_evt_status) // R8
		else $error("error event not recorded in status");

	property p_sloc_w1c;
		@(posedge clk_sys_i) disable iff (rst_i)
		wr_fire && hit_slc && wb_sel_i[0] && !sbe_event_i
		|=> ((sloc_r & $past(wb_dat_i[NSLICE-1:0])) == 4'h0);
	endproperty
	a_sloc_w1c: assert property (p_sloc_w1c) // R9
		else $error("write one did not clear slice flag");

	property p_over_irq;
		@(posedge clk_sys_i) disable iff (rst_i)
		sbe_over_i ##1 !mask_r[EV_SBE_MAX] |=> irq_o;
	endproperty
	a_over_irq: assert property (p_over_irq) // R10
		else $error("threshold overrun did not raise interrupt");

	property p_clr_irq;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_ctl_clr ##1 !(|evt) |=> !irq_o;
	endproperty
	a_clr_irq: assert property (p_clr_irq) // R11
		else $error("control clear left interrupt pending");

	property p_irq_or;
		@(posedge clk_sys_i) disable iff (rst_i)
		##1 irq_o == |($past(stat_r) & $past(mask_r) ^ $past(stat_r));
	endproperty
	a_irq_or: assert property (p_irq_or) // R12
		else $error("interrupt differs from unmasked status");

	property p_sbe_irq;
		@(posedge clk_sys_i) disable iff (rst_i)
		sbe_event_i ##1 !mask_r[EV_SBE] |=> irq_o;
	endproperty
	a_sbe_irq: assert property (p_sbe_irq) // R1
		else $error("unmasked single-bit error gave no interrupt");

	property p_dbe_irq;
		@(posedge clk_sys_i) disable iff (rst_i)
		dbe_event_i ##1 !mask_r[EV_DBE] |=> irq_o;
	endproperty
	a_dbe_irq: assert property (p_dbe_irq) // R2
		else $error("unmasked double-bit error gave no interrupt");

	property p_dover_irq;
		@(posedge clk_sys_i) disable iff (rst_i)
		dbe_over_i ##1 !mask_r[EV_DBE_MAX] |=> irq_o;
	endproperty
	a_dover_irq: assert property (p_dover_irq) // R10
		else $error("double-bit overrun did not raise interrupt");

	property p_rmw_status;
		@(posedge clk_sys_i) disable iff (rst_i)
		rmw_dbe_i |=> stat_r[EV_RMW_DBE];
	endproperty
	a_rmw_status: assert property (p_rmw_status) // R8
		else $error("rmw double-bit error not recorded in status");

	property p_dloc_w1c;
		@(posedge clk_sys_i) disable iff (rst_i)
		wr_fire && hit_dlc && wb_sel_i[0] && !dbe_event_i
		|=> ((dloc_r & $past(wb_dat_i[NSLICE-1:0])) == 4'h0);
	endproperty
	a_dloc_w1c: assert property (p_dloc_w1c) // R9
		else $error("write one did not clear double-bit slice flag");

	property p_masked_kept;
		@(posedge clk_sys_i) disable iff (rst_i)
		sbe_event_i && mask_r[EV_SBE] |=> stat_r[EV_SBE];
	endproperty
	a_masked_kept: assert property (p_masked_kept) // R12
		else $error("masked single-bit error not recorded in status");
endmodule : eim_top
`default_nettype wire
